// ### hdl/cwb_dev.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Code D2h plus one configuration byte
// - Load configuration at parameter acknowledge rising edge
// - Accept only complemented upper nibble
// - Configuration reads return zero upper nibble
// - Busy refuses configuration code and parameter
// - Configuration write points reads at configuration
// - Write updates selects, clears reset flag
// - Code B4h starts a line reset cycle
// - Sample line at short and presence times
// - Busy refuses bus reset code
// - Reset ends within low plus high
// - Line driven soon after acknowledge falls
// - Bus reset points reads at status
// - Busy spans cycle; flags at sample times
// - Speed and active pullup shape the cycle
// - After a bus reset, host waits for idle line before configuration and reset codes
// - Presence flag follows each reset result
// - Short sets flag and forces presence low
// - Pointer codes F0h, E1h, C3h
// - Reset flag set at reset until write
module cwb_dev #(
  parameter logic [6:0]  P_ADDR     = cwb_pkg::DEV_ADDR,
  parameter logic [15:0] P_RSTL_STD = 16'(cwb_pkg::RSTL_STD_CYC),
  parameter logic [15:0] P_RSTH_STD = 16'(cwb_pkg::RSTH_STD_CYC),
  parameter logic [15:0] P_MSP_STD  = 16'(cwb_pkg::MSP_STD_CYC),
  parameter logic [15:0] P_SI_STD   = 16'(cwb_pkg::SI_STD_CYC),
  parameter logic [15:0] P_RSTL_OD  = 16'(cwb_pkg::RSTL_OD_CYC),
  parameter logic [15:0] P_RSTH_OD  = 16'(cwb_pkg::RSTH_OD_CYC),
  parameter logic [15:0] P_MSP_OD   = 16'(cwb_pkg::MSP_OD_CYC),
  parameter logic [15:0] P_SI_OD    = 16'(cwb_pkg::SI_OD_CYC)
) (
  // System
  input  wire logic i_sys_clk,
  input  wire logic i_arst_n,
  // Host link
  cwb_link_if.dev   lnk,
  // Single-wire line
  input  wire logic i_line,
  output logic      o_line_o,
  output logic      o_line_oe_n,
  output logic      o_active_pullup,
  // Settings and flags
  output logic      o_strong_pullup_sel,
  output logic      o_overdrive_sel,
  output logic      o_line_busy_flag,
  output logic      o_presence_seen_flag,
  output logic      o_short_seen_flag,
  output logic      o_reset_flag
);
  import cwb_pkg::*;

  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_ADDR  = 6'b000010,
    S_CMD   = 6'b000100,
    S_PARAM = 6'b001000,
    S_READ  = 6'b010000,
    S_SKIP  = 6'b100000
  } cwb_slave_state_e;

  typedef enum logic [2:0] {
    W_IDLE = 3'b001,
    W_LOW  = 3'b010,
    W_HIGH = 3'b100
  } cwb_wire_state_e;

  cwb_slave_state_e state;
  cwb_wire_state_e  wstate;
  logic [1:0]       scl_sync;
  logic [1:0]       sda_sync;
  logic [1:0]       line_sync;
  logic             scl_prev;
  logic             sda_prev;
  logic [3:0]       bit_cnt;
  logic [7:0]       shreg;
  logic [7:0]       txreg;
  logic [7:0]       cmd;
  logic             rw;
  logic             sda_low;
  logic [3:0]       cfg;
  logic [7:0]       rd_ptr;
  logic [7:0]       rd_val;
  logic [15:0]      cnt;
  logic             line_low;
  logic             busy;
  logic             presence_seen_flag;
  logic             sd;
  logic             rst_flag;
  logic             apu_on;
  logic [15:0]      low_cyc;
  logic [15:0]      high_cyc;
  logic [15:0]      msp_cyc;
  logic [15:0]      si_cyc;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_c;
  logic             stop_c;
  logic             cmd_ok;
  logic             nib_ok;
  logic             cfg_load;
  logic             reset_go;

  // Both link wires and the line are foreign to this clock.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_sync  <= 2'h3;
      sda_sync  <= 2'h3;
      line_sync <= 2'h3;
      scl_prev  <= 1'b1;
      sda_prev  <= 1'b1;
    end else begin
      scl_sync  <= {scl_sync[0], lnk.scl};
      sda_sync  <= {sda_sync[0], lnk.sda};
      line_sync <= {line_sync[0], i_line};
      scl_prev  <= scl_sync[1];
      sda_prev  <= sda_sync[1];
    end
  end

  assign scl_rise = scl_sync[1] & ~scl_prev;
  assign scl_fall = ~scl_sync[1] & scl_prev;
  assign start_c  = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
  assign stop_c   = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];
  assign cmd_ok   = ((shreg == CMD_CFG_WRITE) || (shreg == CMD_BUS_RESET)) && !busy;
  assign nib_ok   = (shreg[7:4] == ~shreg[3:0]);
  assign cfg_load = scl_rise && (bit_cnt == 4'h8) && (state == S_PARAM) && sda_low;
  assign reset_go = scl_fall && (bit_cnt == 4'h8) && (state == S_CMD) && sda_low
                    && (cmd == CMD_BUS_RESET);

  // Register selected for reads; the data register belongs to byte commands.
  always_comb begin
    case (rd_ptr)
      PTR_STATUS: rd_val = {3'h0, rst_flag, line_sync[1], sd, presence_seen_flag, busy};
      PTR_CONFIG: rd_val = {4'h0, cfg};
      default:    rd_val = 8'h00;
    endcase
  end

  // Byte engine: sample on rising edges, change the data wire on falling edges.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state   <= S_IDLE;
      bit_cnt <= 4'h0;
      shreg   <= 8'h00;
      txreg   <= 8'h00;
      cmd     <= 8'h00;
      rw      <= 1'b0;
      sda_low <= 1'b0;
    end else if (start_c) begin
      state   <= S_ADDR;
      bit_cnt <= 4'hf; // The clock fall that closes a start carries no data bit.
      sda_low <= 1'b0;
    end else if (stop_c) begin
      state   <= S_IDLE;
      bit_cnt <= 4'h0;
      sda_low <= 1'b0;
    end else if (scl_rise) begin
      if (bit_cnt < 4'h8) begin
        shreg <= {shreg[6:0], sda_sync[1]};
      end else if (state == S_READ && sda_sync[1]) begin
        state <= S_SKIP;
      end
    end else if (scl_fall) begin
      if (bit_cnt == 4'h7) begin
        bit_cnt <= 4'h8;
        unique case (state)
          S_ADDR: begin
            sda_low <= (shreg[7:1] == P_ADDR);
            rw      <= shreg[0];
          end
          S_CMD: begin
            sda_low <= cmd_ok;
            cmd     <= shreg;
          end
          S_PARAM: sda_low <= nib_ok && !busy;
          S_READ:  sda_low <= 1'b0;
          S_IDLE:  sda_low <= 1'b0;
          S_SKIP:  sda_low <= 1'b0;
        endcase
      end else if (bit_cnt == 4'h8) begin
        bit_cnt <= 4'h0;
        sda_low <= 1'b0;
        unique case (state)
          S_ADDR: begin
            if (sda_low && rw) begin
              state   <= S_READ;
              txreg   <= {rd_val[6:0], 1'b0};
              sda_low <= ~rd_val[7];
            end else begin
              state <= sda_low ? S_CMD : S_SKIP;
            end
          end
          S_CMD:   state <= (sda_low && cmd == CMD_CFG_WRITE) ? S_PARAM : S_SKIP;
          S_PARAM: state <= S_SKIP;
          S_READ: begin
            txreg   <= {rd_val[6:0], 1'b0};
            sda_low <= ~rd_val[7];
          end
          S_IDLE:  state <= S_IDLE;
          S_SKIP:  state <= S_SKIP;
        endcase
      end else begin
        bit_cnt <= bit_cnt + 4'h1;
        if (state == S_READ) begin
          sda_low <= ~txreg[7];
          txreg   <= {txreg[6:0], 1'b0};
        end
      end
    end
  end

  // Settings and read pointer; a configuration write never touches the line.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg      <= CFG_RESET;
      rst_flag <= 1'b1;
      rd_ptr   <= PTR_STATUS;
    end else if (cfg_load) begin
      cfg      <= shreg[3:0];
      rst_flag <= 1'b0;
      rd_ptr   <= PTR_CONFIG;
    end else if (reset_go) begin
      rd_ptr <= PTR_STATUS;
    end
  end

  // Phase lengths follow the speed select in force.
  assign low_cyc  = cfg[CFG_OVD_BIT] ? P_RSTL_OD : P_RSTL_STD;
  assign high_cyc = cfg[CFG_OVD_BIT] ? P_RSTH_OD : P_RSTH_STD;
  assign msp_cyc  = cfg[CFG_OVD_BIT] ? P_MSP_OD : P_MSP_STD;
  assign si_cyc   = cfg[CFG_OVD_BIT] ? P_SI_OD : P_SI_STD;

  // Reset/presence cycle. The short sample must precede the presence sample.
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wstate   <= W_IDLE;
      cnt      <= 16'h0000;
      line_low <= 1'b0;
      busy     <= 1'b0;
      presence_seen_flag      <= 1'b0;
      sd       <= 1'b0;
      apu_on   <= 1'b0;
    end else begin
      unique case (wstate)
        W_IDLE: begin
          if (reset_go) begin
            wstate   <= W_LOW;
            cnt      <= 16'h0000;
            line_low <= 1'b1;
            busy     <= 1'b1;
          end
        end
        W_LOW: begin
          cnt <= cnt + 16'h0001;
          if (cnt == low_cyc - 16'h0001) begin
            wstate   <= W_HIGH;
            cnt      <= 16'h0000;
            line_low <= 1'b0;
            apu_on   <= cfg[CFG_APU_BIT];
          end
        end
        W_HIGH: begin
          cnt <= cnt + 16'h0001;
          if (cnt == si_cyc) begin
            sd <= ~line_sync[1];
            if (!line_sync[1]) begin
              presence_seen_flag <= 1'b0;
            end
          end
          if (cnt == msp_cyc) begin
            presence_seen_flag <= ~line_sync[1] & ~sd;
          end
          if (cnt == high_cyc - 16'h0001) begin
            wstate <= W_IDLE;
            busy   <= 1'b0;
            apu_on <= 1'b0;
          end
        end
      endcase
    end
  end

  assign lnk.dev_sda_o        = 1'b0;
  assign lnk.dev_sda_oe_n     = ~sda_low;
  assign o_line_o             = 1'b0;
  assign o_line_oe_n          = ~line_low;
  assign o_active_pullup      = apu_on;
  assign o_strong_pullup_sel  = cfg[CFG_SPU_BIT];
  assign o_overdrive_sel      = cfg[CFG_OVD_BIT];
  assign o_line_busy_flag     = busy;
  assign o_presence_seen_flag = presence_seen_flag;
  assign o_short_seen_flag    = sd;
  assign o_reset_flag         = rst_flag;
endmodule // cwb_dev
`default_nettype wire

// ### hdl/cwb_pkg.sv
package cwb_pkg;
  // Core clock period.
  localparam int CLK_NS = 25;

  // Command and pointer codes.
  localparam logic [7:0] CMD_CFG_WRITE = 8'hd2;
  localparam logic [7:0] CMD_BUS_RESET = 8'hb4;
  localparam logic [7:0] PTR_STATUS    = 8'hf0;
  localparam logic [7:0] PTR_DATA      = 8'he1;
  localparam logic [7:0] PTR_CONFIG    = 8'hc3;

  // Bridge address; the value is arbitrary.
  localparam logic [6:0] DEV_ADDR = 7'h2a;

  // Configuration and status field positions, reset values.
  localparam int CFG_APU_BIT = 0;
  localparam int CFG_SPU_BIT = 2;
  localparam int CFG_OVD_BIT = 3;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_PPD_BIT  = 1;
  localparam int ST_SD_BIT   = 2;
  localparam int ST_LVL_BIT  = 3;
  localparam int ST_RST_BIT  = 4;
  localparam logic [3:0] CFG_RESET = 4'h0;

  // Line timing in ns, standard and overdrive, and cycle counts rounded up.
  localparam int RSTL_STD_NS = 600000;
  localparam int RSTH_STD_NS = 600000;
  localparam int MSP_STD_NS  = 70000;
  localparam int SI_STD_NS   = 8000;
  localparam int RSTL_OD_NS  = 60000;
  localparam int RSTH_OD_NS  = 60000;
  localparam int MSP_OD_NS   = 8000;
  localparam int SI_OD_NS    = 1000;
  localparam int RSTL_STD_CYC = (RSTL_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RSTH_STD_CYC = (RSTH_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int MSP_STD_CYC  = (MSP_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int SI_STD_CYC   = (SI_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RSTL_OD_CYC  = (RSTL_OD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RSTH_OD_CYC  = (RSTH_OD_NS + CLK_NS - 1) / CLK_NS;
  localparam int MSP_OD_CYC   = (MSP_OD_NS + CLK_NS - 1) / CLK_NS;
  localparam int SI_OD_CYC    = (SI_OD_NS + CLK_NS - 1) / CLK_NS;

  // Latest start of line activity after the acknowledge falling edge.
  localparam int ACT_MAX_PS  = 262500;
  localparam int ACT_MAX_CYC = ACT_MAX_PS / (CLK_NS * 1000);

  // Host serial clock, quarter period in cycles.
  localparam int I2C_PERIOD_NS = 10000;
  localparam int I2C_QTR_CYC   = I2C_PERIOD_NS / 4 / CLK_NS;

  // Host operations.
  localparam logic [1:0] OP_CFG  = 2'h0;
  localparam logic [1:0] OP_RST  = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
endpackage

// ### hdl/cwb_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface cwb_link_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  // Open-drain wires with pullups.
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport host (output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n, input scl, sda);
  modport dev (output dev_sda_o, dev_sda_oe_n, input scl, sda);
endinterface
`default_nettype wire

// ### hdl/cwb_host.sv
`timescale 1ns/10ps
`default_nettype none
module cwb_host #(
  parameter logic [6:0]  P_ADDR = cwb_pkg::DEV_ADDR,
  parameter logic [15:0] P_QTR  = 16'(cwb_pkg::I2C_QTR_CYC)
) (
  // System
  input  wire logic       i_sys_clk,
  input  wire logic       i_arst_n,
  // Host link
  cwb_link_if.host        lnk,
  // Command port
  input  wire logic       i_cmd_valid,
  input  wire logic [1:0] i_cmd_op,
  input  wire logic [3:0] i_cfg_value,
  output logic            o_cmd_ready,
  output logic            o_done,
  output logic            o_nack,
  output logic [7:0]      o_rd_data,
  output logic            o_poll_pending
);
  import cwb_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_START = 4'b0010,
    H_BIT   = 4'b0100,
    H_STOP  = 4'b1000
  } cwb_host_state_e;

  cwb_host_state_e state;
  logic [1:0]      sda_sync;
  logic [15:0]     qcnt;
  logic [1:0]      q;
  logic [3:0]      bitn;
  logic [1:0]      bidx;
  logic [1:0]      last;
  logic [7:0]      tx [0:2];
  logic [7:0]      rxsh;
  logic [1:0]      cur_op;
  logic            is_poll;
  logic            nack;
  logic            pend;
  logic [1:0]      pend_op;
  logic [3:0]      pend_val;
  logic            poll_due;
  logic            scl_low;
  logic            sda_low;
  logic            tick;
  logic            poll_now;
  logic            recv;

  assign tick     = (qcnt == P_QTR - 16'h0001);
  // Configuration and reset commands after a bus reset wait for a status read showing the line idle.
  assign poll_now = poll_due && (pend_op != OP_READ);
  assign recv     = (cur_op == OP_READ) && (bidx == 2'h1);

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sda_sync <= 2'h3;
    end else begin
      sda_sync <= {sda_sync[0], lnk.sda};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state     <= H_IDLE;
      qcnt      <= 16'h0000;
      q         <= 2'h0;
      bitn      <= 4'h0;
      bidx      <= 2'h0;
      last      <= 2'h0;
      tx[0]     <= 8'h00;
      tx[1]     <= 8'h00;
      tx[2]     <= 8'h00;
      rxsh      <= 8'h00;
      cur_op    <= OP_CFG;
      is_poll   <= 1'b0;
      nack      <= 1'b0;
      pend      <= 1'b0;
      pend_op   <= OP_CFG;
      pend_val  <= 4'h0;
      poll_due  <= 1'b0;
      scl_low   <= 1'b0;
      sda_low   <= 1'b0;
      o_done    <= 1'b0;
      o_nack    <= 1'b0;
      o_rd_data <= 8'h00;
    end else begin
      o_done <= 1'b0;
      if (i_cmd_valid && !pend) begin
        pend     <= 1'b1;
        pend_op  <= i_cmd_op;
        pend_val <= i_cfg_value;
      end
      if (state != H_IDLE) begin
        qcnt <= tick ? 16'h0000 : qcnt + 16'h0001;
        if (tick) begin
          q <= q + 2'h1;
        end
      end
      unique case (state)
        H_IDLE: begin
          if (pend) begin
            state   <= H_START;
            qcnt    <= 16'h0000;
            q       <= 2'h0;
            bidx    <= 2'h0;
            bitn    <= 4'h0;
            nack    <= 1'b0;
            is_poll <= poll_now;
            cur_op  <= poll_now ? OP_READ : pend_op;
            tx[0]   <= {P_ADDR, poll_now || pend_op == OP_READ};
            tx[1]   <= (pend_op == OP_CFG) ? CMD_CFG_WRITE : CMD_BUS_RESET;
            tx[2]   <= {~pend_val, pend_val};
            last    <= (!poll_now && pend_op == OP_CFG) ? 2'h2 : 2'h1;
            if (!poll_now) begin
              pend <= 1'b0;
            end
          end
        end
        H_START: begin
          if (tick && q == 2'h0) begin
            sda_low <= 1'b1;
          end
          if (tick && q == 2'h1) begin
            scl_low <= 1'b1;
            state   <= H_BIT;
            q       <= 2'h0;
          end
        end
        H_BIT: begin
          if (tick) begin
            unique case (q)
              2'h0: sda_low <= (bitn < 4'h8) && !recv && !tx[bidx][~bitn[2:0]];
              2'h1: scl_low <= 1'b0;
              2'h2: begin
                if (bitn < 4'h8 && recv) begin
                  rxsh <= {rxsh[6:0], sda_sync[1]};
                end
                if (bitn == 4'h8 && !recv && sda_sync[1]) begin
                  nack <= 1'b1;
                end
              end
              2'h3: begin
                scl_low <= 1'b1;
                if (bitn == 4'h8) begin
                  bitn <= 4'h0;
                  if (nack || bidx == last) begin
                    state <= H_STOP;
                  end else begin
                    bidx <= bidx + 2'h1;
                  end
                end else begin
                  bitn <= bitn + 4'h1;
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            unique case (q)
              2'h0: sda_low <= 1'b1;
              2'h1: scl_low <= 1'b0;
              2'h2: sda_low <= 1'b0;
              2'h3: begin
                state <= H_IDLE;
                if (!is_poll) begin
                  o_done <= 1'b1;
                  o_nack <= nack;
                  if (cur_op == OP_READ) begin
                    o_rd_data <= rxsh;
                  end
                end
                if (cur_op == OP_RST && !nack && !is_poll) begin
                  poll_due <= 1'b1;
                end
                if (is_poll && !nack && !rxsh[ST_BUSY_BIT]) begin
                  poll_due <= 1'b0;
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  assign lnk.host_scl_o    = 1'b0;
  assign lnk.host_scl_oe_n = ~scl_low;
  assign lnk.host_sda_o    = 1'b0;
  assign lnk.host_sda_oe_n = ~sda_low;
  assign o_cmd_ready       = ~pend;
  assign o_poll_pending    = poll_due;
endmodule // cwb_host
`default_nettype wire

// ### tb/cwb_cfg_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module cwb_cfg_monitor #(
  parameter int P_RSTL_STD = 40,
  parameter int P_RSTH_STD = 40,
  parameter int P_RSTL_OD  = 24,
  parameter int P_RSTH_OD  = 24
) (
  // System
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // Link
  input wire logic scl,
  input wire logic dev_sda_oe_n,
  // Line and flags
  input wire logic o_line_oe_n,
  input wire logic o_active_pullup,
  input wire logic o_overdrive_sel,
  input wire logic o_line_busy_flag,
  input wire logic o_presence_seen_flag,
  input wire logic o_short_seen_flag,
  input wire logic o_reset_flag
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);

  logic [15:0] busy_cnt;
  logic [15:0] low_cnt;
  logic [15:0] want_busy;
  logic [15:0] want_low;

  // The speed cannot change mid-cycle, so the current select gives the expected lengths.
  assign want_low  = o_overdrive_sel ? 16'(P_RSTL_OD) : 16'(P_RSTL_STD);
  assign want_busy = o_overdrive_sel ? 16'(P_RSTL_OD + P_RSTH_OD) : 16'(P_RSTL_STD + P_RSTH_STD);

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) busy_cnt <= 16'h0000;
    else busy_cnt <= o_line_busy_flag ? busy_cnt + 16'h0001 : 16'h0000;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) low_cnt <= 16'h0000;
    else low_cnt <= !o_line_oe_n ? low_cnt + 16'h0001 : 16'h0000;
  end

  property p_busy_len;
    $fell(o_line_busy_flag) |-> (busy_cnt + 16'h0001 >= want_busy) && (busy_cnt <= want_busy + 16'h0001);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");

  property p_low_len;
    $rose(o_line_oe_n) |-> (low_cnt + 16'h0001 >= want_low) && (low_cnt <= want_low + 16'h0001);
  endproperty
  a_low_len: assert property (p_low_len) else $error("reset low length wrong");

  property p_drive_busy;
    !o_line_oe_n |-> o_line_busy_flag;
  endproperty
  a_drive_busy: assert property (p_drive_busy) else $error("line driven while idle");

  property p_busy_start;
    $rose(o_line_busy_flag) |-> ##[0:3] !o_line_oe_n;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("reset low late");

  property p_pullup;
    o_active_pullup |-> o_line_oe_n && o_line_busy_flag;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pullup outside high phase");

  property p_short_pres;
    o_short_seen_flag |-> !o_presence_seen_flag;
  endproperty
  a_short_pres: assert property (p_short_pres) else $error("presence with short");

  property p_flags_idle;
    !o_line_busy_flag && !$past(o_line_busy_flag) |-> $stable(o_presence_seen_flag) && $stable(o_short_seen_flag);
  endproperty
  a_flags_idle: assert property (p_flags_idle) else $error("flags moved while idle");

  property p_rst_flag;
    !$rose(o_reset_flag);
  endproperty
  a_rst_flag: assert property (p_rst_flag) else $error("reset flag set by traffic");

  property p_dev_sda;
    $changed(dev_sda_oe_n) |-> !scl;
  endproperty
  a_dev_sda: assert property (p_dev_sda) else $error("device data moved with clock high");

  c_busy: cover property ($rose(o_line_busy_flag));
  c_short: cover property ($rose(o_short_seen_flag));
  c_pres: cover property ($rose(o_presence_seen_flag));
  c_cfg: cover property ($fell(o_reset_flag));
endmodule // cwb_cfg_monitor
`default_nettype wire

// ### tb/cfg_write_and_bus_reset_tb.sv
`timescale 1ns/10ps
`default_nettype none
module cfg_write_and_bus_reset_tb;
  import cwb_pkg::*;
  localparam int RL_S = 40;
  localparam int RH_S = 40;
  localparam int RL_O = 24;
  localparam int RH_O = 24;

  logic       i_sys_clk = 1'b0;
  logic       i_arst_n  = 1'b0;
  logic       i_line    = 1'b1;
  logic       cmd_valid = 1'b0;
  logic [1:0] cmd_op    = 2'h0;
  logic [3:0] cfg_value = 4'h0;
  logic       cmd_ready, done, nack, poll_pending;
  logic [7:0] rd_data;
  logic       line_o, line_oe_n, act_pu, spu_sel, ovd_sel, busy, pres, shrt, rst_fl;
  logic       short_en = 1'b0;
  logic       pres_en  = 1'b0;
  int         rel = 0;
  int         bad_count = 0;
  int         comparisons = 0;

  always #12.5 i_sys_clk = ~i_sys_clk;

  cwb_link_if cwb_link_if_i ();

  cwb_host #(.P_ADDR(DEV_ADDR), .P_QTR(16'h0008)) cwb_host_i (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .lnk(cwb_link_if_i.host),
    .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_cfg_value(cfg_value), .o_cmd_ready(cmd_ready),
    .o_done(done), .o_nack(nack), .o_rd_data(rd_data), .o_poll_pending(poll_pending));

  cwb_dev #(.P_ADDR(DEV_ADDR), .P_RSTL_STD(16'(RL_S)), .P_RSTH_STD(16'(RH_S)), .P_MSP_STD(16'h0014),
    .P_SI_STD(16'h0006), .P_RSTL_OD(16'(RL_O)), .P_RSTH_OD(16'(RH_O)), .P_MSP_OD(16'h000c),
    .P_SI_OD(16'h0005)) cwb_dev_i (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .lnk(cwb_link_if_i.dev), .i_line(i_line),
    .o_line_o(line_o), .o_line_oe_n(line_oe_n), .o_active_pullup(act_pu), .o_strong_pullup_sel(spu_sel),
    .o_overdrive_sel(ovd_sel), .o_line_busy_flag(busy), .o_presence_seen_flag(pres),
    .o_short_seen_flag(shrt), .o_reset_flag(rst_fl));

  cwb_cfg_monitor #(.P_RSTL_STD(RL_S), .P_RSTH_STD(RH_S), .P_RSTL_OD(RL_O), .P_RSTH_OD(RH_O)) cwb_cfg_monitor_i (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .scl(cwb_link_if_i.scl),
    .dev_sda_oe_n(cwb_link_if_i.dev_sda_oe_n), .o_line_oe_n(line_oe_n), .o_active_pullup(act_pu),
    .o_overdrive_sel(ovd_sel), .o_line_busy_flag(busy), .o_presence_seen_flag(pres),
    .o_short_seen_flag(shrt), .o_reset_flag(rst_fl));

  // Slave model: a presence pulse well clear of the short sample and spanning the presence sample.
  always @(negedge i_sys_clk) begin
    rel <= !line_oe_n ? 0 : (rel < 1000 ? rel + 1 : rel);
    i_line <= !short_en && line_oe_n && !(pres_en && rel >= 9 && rel < 26);
  end

  function automatic logic [7:0] st(input logic rst, input logic ll, input logic sd, input logic pd);
    logic [7:0] s;
    s = 8'h00;
    s[ST_RST_BIT] = rst;
    s[ST_LVL_BIT] = ll;
    s[ST_SD_BIT]  = sd;
    s[ST_PPD_BIT] = pd;
    return s;
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic fail_wait(input int n);
    if (n >= 40000) begin
      bad_count++;
      $display("mismatch wait expected done seen timeout");
      summarize();
    end
  endtask

  // One command through the host port; the request holds until taken, then waits for done.
  task automatic run(input logic [1:0] op, input logic [3:0] v);
    int n;
    @(negedge i_sys_clk);
    cmd_valid = 1'b1;
    cmd_op    = op;
    cfg_value = v;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 40000) begin
      @(negedge i_sys_clk);
      n++;
    end
    fail_wait(n);
    @(negedge i_sys_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40000) begin
      @(negedge i_sys_clk);
      n++;
    end
    fail_wait(n);
  endtask

  initial begin
    repeat (12) @(negedge i_sys_clk);
    i_arst_n = 1'b1;
    check("reset_flag", {7'h00, rst_fl}, 8'h01);
    run(OP_READ, 4'h0);
    check("status_por", rd_data, st(1'b1, 1'b1, 1'b0, 1'b0));
    run(OP_CFG, 4'h9);
    check("cfg_nack", {7'h00, nack}, 8'h00);
    check("rst_cleared", {7'h00, rst_fl}, 8'h00);
    check("ovd_sel", {7'h00, ovd_sel}, 8'h01);
    check("spu_sel", {7'h00, spu_sel}, 8'h00);
    run(OP_READ, 4'h0);
    check("cfg_read", rd_data, 8'h09);
    pres_en = 1'b1;
    run(OP_RST, 4'h0);
    check("rst_nack", {7'h00, nack}, 8'h00);
    check("poll_pending", {7'h00, poll_pending}, 8'h01);
    run(OP_READ, 4'h0);
    check("status_pres_od", rd_data, st(1'b0, 1'b1, 1'b0, 1'b1));
    pres_en  = 1'b0;
    short_en = 1'b1;
    run(OP_RST, 4'h0);
    run(OP_READ, 4'h0);
    check("status_short", rd_data, st(1'b0, 1'b0, 1'b1, 1'b0));
    short_en = 1'b0;
    run(OP_CFG, 4'h4);
    check("spu_sel2", {7'h00, spu_sel}, 8'h01);
    check("ovd_sel2", {7'h00, ovd_sel}, 8'h00);
    run(OP_READ, 4'h0);
    check("cfg_read2", rd_data, 8'h04);
    run(OP_RST, 4'h0);
    run(OP_READ, 4'h0);
    check("status_none", rd_data, st(1'b0, 1'b1, 1'b0, 1'b0));
    pres_en = 1'b1;
    run(OP_RST, 4'h0);
    run(OP_READ, 4'h0);
    check("status_pres_std", rd_data, st(1'b0, 1'b1, 1'b0, 1'b1));
    summarize();
  end
endmodule // cfg_write_and_bus_reset_tb
`default_nettype wire
